// ### rtl/rpi_pkg.sv
package rpi_pkg;
   // ==================================================
   // timing
   localparam int CLK_PS = 5000;
   localparam int REF_PS = 20000;
   localparam int TXC1G_PS = 8000;
   localparam int TXC100_PS = 40000;
   localparam int TXC10_PS = 400000;
   localparam int H1G = TXC1G_PS / 2 / CLK_PS;
   localparam logic [6:0] HALF_REF = 7'(REF_PS / 2 / CLK_PS);
   localparam logic [6:0] HALF_1G = 7'((H1G > 0) ? H1G : 1);
   localparam logic [6:0] HALF_100 = 7'(TXC100_PS / 2 / CLK_PS);
   localparam logic [6:0] HALF_10 = 7'(TXC10_PS / 2 / CLK_PS);
   localparam logic [3:0] RMII10_REP = 4'h9;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // ==================================================
   // delay line
   localparam int DLY_MIN_PS = 1690;
   localparam int DLY_MAX_PS = 2550;
   localparam int DLY_NOM_PS = 2000;
   localparam logic [3:0] DLY_TAP_NOM =
      4'((DLY_NOM_PS - DLY_MIN_PS) * 15 / (DLY_MAX_PS - DLY_MIN_PS));
   // ==================================================
   // register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DLY = 4'h1;
   localparam logic [3:0] ADDR_STAT = 4'h2;
   localparam int STAT_RXERR = 2;
   localparam logic [7:0] CTRL_RST = 8'h54;
   // ==================================================
   // types
   typedef enum logic [1:0] {
      MODE_RMII = 2'h0, MODE_RGMII = 2'h1, MODE_SGMII = 2'h2, MODE_BAD = 2'h3
   } rpi_mode_t;
   typedef enum logic [1:0] {
      SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2, SPD_BAD = 2'h3
   } rpi_speed_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} rpi_tx_st_t;
   typedef struct packed {
      logic partner_mac;
      logic an_en;
      logic ext_ref;
      logic full_dup;
      rpi_speed_t speed;
      rpi_mode_t mode;
   } rpi_ctrl_t;
   typedef struct packed {
      logic [3:0] tx_tap;
      logic [3:0] rx_tap;
      logic tx_en;
      logic rx_en;
   } rpi_dly_t;
   typedef struct packed {
      logic drive_max;
      logic sgmii_en;
      logic sgmii_an;
      logic half_dup;
      rpi_speed_t speed;
      logic rx_dly;
      logic tx_dly;
      logic [3:0] rx_tap;
      logic [3:0] tx_tap;
   } rpi_cfg_t;
   typedef struct packed {
      logic err;
      logic [7:0] data;
   } rpi_byte_t;
   // ==================================================
   // half period of the transmit clock in system cycles
   function automatic logic [6:0] rpi_half(input logic rmii, input rpi_speed_t s);
      if (rmii) return HALF_REF;
      case (s)
         SPD_1000: return HALF_1G;
         SPD_10: return HALF_10;
         default: return HALF_100;
      endcase
   endfunction : rpi_half
   // last symbol index of one byte
   function automatic logic [1:0] rpi_last(input logic rmii, input rpi_speed_t s);
      if (rmii) return 2'h3;
      return (s == SPD_1000) ? 2'h0 : 2'h1;
   endfunction : rpi_last
endpackage : rpi_pkg

// ### rtl/rpi_clk_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rpi_clk_gen (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ext_sel,
   input wire logic ext_pin,
   input wire logic [6:0] half,
   output logic pin_q,
   output logic rise_q,
   output logic fall_q
);
   logic [6:0] cnt_q;
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // ==================================================
   // external reference, two-flop synchroniser
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= ext_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // ==================================================
   // divider; >= keeps a speed change from running the count away
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= 7'h00;
         pin_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (ext_sel) begin
         cnt_q <= 7'h00;
         pin_q <= 1'b0;
         rise_q <= s2_q & ~s3_q;
         fall_q <= ~s2_q & s3_q;
      end else if (cnt_q >= half - 7'h01) begin
         cnt_q <= 7'h00;
         pin_q <= ~pin_q;
         rise_q <= ~pin_q;
         fall_q <= pin_q;
      end else begin
         cnt_q <= cnt_q + 7'h01;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
   end
endmodule : rpi_clk_gen
`default_nettype wire

// ### rtl/rpi_port.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - rmii timed by 50 MHz reference
// - rmii runs only 10 or 100
// - rmii receive two lines, reference timed
// - rmii transmit control is tx enable
// - rgmii 10/100/1000, gigabit double edge
// - gigabit 125 MHz (clock here runs at 100 MHz, half period one system cycle), low nibble rise
// - 10/100 low nibble, repeat on fall
// - tx control rise en, fall en^er
// - host port delays from straps
// - other ports delays by software
// - delay at one stage per path
// - strap high gives strongest host drive in rgmii
// - sgmii only on ports 1 to 4
// - sgmii full duplex, autoneg or forced
// - mac partner: autoneg off, same speed
// - link input low means link up
// - half duplex not at 1000
module rpi_port #(
   parameter int PORT_NUM = 1,
   parameter bit IS_HOST = 1'b0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic tx_valid,
   input wire rpi_pkg::rpi_byte_t tx_in,
   output logic tx_ready,
   output logic rx_valid,
   output rpi_pkg::rpi_byte_t rx_out,
   input wire logic port_transmit_clock_pin_i,
   output logic port_transmit_clock_pin_o,
   output logic port_transmit_clock_pin_oe_n,
   output logic port_transmit_control,
   output logic [3:0] port_transmit_data,
   input wire logic port_receive_clock,
   input wire logic port_receive_control,
   input wire logic [2:0] port_receive_data,
   input wire logic port_receive_data_bit3,
   input wire logic port_link_indication_n,
   input wire logic strap_drive_hi,
   input wire logic strap_rx_delay,
   input wire logic strap_tx_delay,
   output rpi_pkg::rpi_cfg_t phy_cfg
);
   localparam bit PORT_OK = (PORT_NUM >= 1) && (PORT_NUM <= 4);
   // ==================================================
   // declarations
   rpi_pkg::rpi_ctrl_t ctrl_q;
   rpi_pkg::rpi_dly_t dly_q;
   rpi_pkg::rpi_cfg_t cfg_q;
   rpi_pkg::rpi_byte_t cur_q;
   rpi_pkg::rpi_byte_t rx_q;
   rpi_pkg::rpi_tx_st_t st_q;
   logic [9:0] s1_q;
   logic [9:0] s2_q;
   logic rxc_d_q;
   logic [2:0] strap_q;
   logic [1:0] scnt_q;
   logic link_up_q;
   logic cfg_err_q;
   logic rx_err_q;
   logic [31:0] rdata_q;
   logic oe_n_q;
   logic txctl_q;
   logic [3:0] txd_q;
   logic [1:0] idx_q;
   logic [3:0] rep_q;
   logic ready_q;
   logic [7:0] sh_q;
   logic [3:0] lo_q;
   logic dv_q;
   logic racc_q;
   logic [1:0] ridx_q;
   logic [3:0] rrep_q;
   logic rvalid_q;
   logic rmii;
   logic rgmii;
   logic gig;
   logic ext_sel;
   logic [6:0] half;
   logic [1:0] last;
   logic [3:0] reload;
   logic busy;
   logic slot;
   logic ref_pin;
   logic ref_rise;
   logic ref_fall;
   logic rxc_rise;
   logic rxc_fall;
   logic rx_ctl;
   logic [3:0] rxd;
   logic ferr;
   // ==================================================
   // symbol of a byte: rmii dibit or rgmii nibble
   function automatic logic [3:0] sym(input logic [7:0] b, input logic [1:0] i,
                                      input logic r);
      logic [7:0] t;
      t = b >> {i, 1'b0};
      if (r) return {2'h0, t[1:0]};
      return i[0] ? b[7:4] : b[3:0];
   endfunction : sym
   // ==================================================
   // mode decode
   assign rmii = ctrl_q.mode == rpi_pkg::MODE_RMII;
   assign rgmii = ctrl_q.mode == rpi_pkg::MODE_RGMII;
   assign gig = cfg_q.speed == rpi_pkg::SPD_1000;
   assign ext_sel = rmii & ctrl_q.ext_ref;
   assign half = rpi_pkg::rpi_half(rmii, cfg_q.speed);
   assign last = rpi_pkg::rpi_last(rmii, cfg_q.speed);
   assign reload = (rmii && cfg_q.speed == rpi_pkg::SPD_10) ? rpi_pkg::RMII10_REP : 4'h0;
   assign busy = st_q == rpi_pkg::TX_SEND;
   assign rx_ctl = s2_q[1];
   assign rxd = s2_q[5:2];
   // ==================================================
   // pin synchronisers; rxc goes through the same two flops as data
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s1_q <= 10'h040;
         s2_q <= 10'h040;
         rxc_d_q <= 1'b0;
      end else begin
         s1_q <= {strap_tx_delay, strap_rx_delay, strap_drive_hi, port_link_indication_n,
                  port_receive_data_bit3, port_receive_data, port_receive_control,
                  port_receive_clock};
         s2_q <= s1_q;
         rxc_d_q <= s2_q[0];
      end
   end
   assign rxc_rise = s2_q[0] & ~rxc_d_q;
   assign rxc_fall = ~s2_q[0] & rxc_d_q;
   // ==================================================
   // reference or transmit clock
   rpi_clk_gen u_clk (
      .clock(clock),
      .sys_rst(sys_rst),
      .ext_sel(ext_sel),
      .ext_pin(port_transmit_clock_pin_i),
      .half(half),
      .pin_q(ref_pin),
      .rise_q(ref_rise),
      .fall_q(ref_fall)
   );
   // data leaves one cycle after the pin falls, so it is settled at the rise except at gigabit, where it leaves on the rise edge;
   // rgmii puts its fall half out one cycle after the rise in the same way
   assign slot = ref_fall;
   // ==================================================
   // straps caught once the synchroniser has carried them
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         scnt_q <= 2'h0;
         strap_q <= 3'h0;
      end else if (scnt_q != rpi_pkg::STRAP_WAIT) begin
         scnt_q <= scnt_q + 2'h1;
         if (scnt_q == rpi_pkg::STRAP_WAIT - 2'h1) strap_q <= s2_q[9:7];
      end
   end
   // ==================================================
   // active-low link
   always_ff @(posedge clock) begin
      if (sys_rst) link_up_q <= 1'b0;
      else link_up_q <= ~s2_q[6];
   end
   // ==================================================
   // control registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_q <= rpi_pkg::rpi_ctrl_t'(rpi_pkg::CTRL_RST);
         dly_q <= '{rpi_pkg::DLY_TAP_NOM, rpi_pkg::DLY_TAP_NOM, 1'b0, 1'b1};
      end else if (reg_wr) begin
         if (reg_addr == rpi_pkg::ADDR_CTRL) ctrl_q <= rpi_pkg::rpi_ctrl_t'(reg_wdata[7:0]);
         if (reg_addr == rpi_pkg::ADDR_DLY) dly_q <= rpi_pkg::rpi_dly_t'(reg_wdata[9:0]);
      end
   end
   // ==================================================
   // effective configuration toward pads, delay lines and serdes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cfg_q <= '0;
         cfg_err_q <= 1'b0;
      end else begin
         if (ctrl_q.speed == rpi_pkg::SPD_BAD ||
             (rmii && ctrl_q.speed == rpi_pkg::SPD_1000))
            cfg_q.speed <= rpi_pkg::SPD_100;
         else
            cfg_q.speed <= ctrl_q.speed;
         cfg_q.half_dup <= ~ctrl_q.full_dup && ctrl_q.speed != rpi_pkg::SPD_1000 &&
                           ctrl_q.mode != rpi_pkg::MODE_SGMII;
         cfg_q.sgmii_en <= ctrl_q.mode == rpi_pkg::MODE_SGMII && PORT_OK;
         cfg_q.sgmii_an <= ctrl_q.mode == rpi_pkg::MODE_SGMII && PORT_OK &&
                           ctrl_q.an_en && ~ctrl_q.partner_mac;
         cfg_q.rx_dly <= IS_HOST ? strap_q[1] : dly_q.rx_en;
         cfg_q.tx_dly <= IS_HOST ? strap_q[2] : dly_q.tx_en;
         cfg_q.rx_tap <= IS_HOST ? rpi_pkg::DLY_TAP_NOM : dly_q.rx_tap;
         cfg_q.tx_tap <= IS_HOST ? rpi_pkg::DLY_TAP_NOM : dly_q.tx_tap;
         cfg_q.drive_max <= IS_HOST && rgmii && strap_q[0];
         cfg_err_q <= ctrl_q.mode == rpi_pkg::MODE_BAD ||
                      (ctrl_q.mode == rpi_pkg::MODE_SGMII && !PORT_OK) ||
                      (rmii && ctrl_q.speed == rpi_pkg::SPD_1000);
      end
   end
   // ==================================================
   // clock pin drive; released when fed from outside or in sgmii
   always_ff @(posedge clock) begin
      if (sys_rst) oe_n_q <= 1'b1;
      else oe_n_q <= ext_sel | ~(rmii | rgmii);
   end
   // ==================================================
   // transmit serialiser; takes a new byte only while the link is up
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= rpi_pkg::TX_IDLE;
         cur_q <= '0;
         idx_q <= 2'h0;
         rep_q <= 4'h0;
         ready_q <= 1'b0;
         txd_q <= 4'h0;
         txctl_q <= 1'b0;
      end else begin
         ready_q <= 1'b0;
         if (slot && rep_q != 4'h0) begin
            rep_q <= rep_q - 4'h1;
         end else if (slot) begin
            rep_q <= reload;
            if (busy && idx_q != last) begin
               idx_q <= idx_q + 2'h1;
               txd_q <= sym(cur_q.data, idx_q + 2'h1, rmii);
               txctl_q <= 1'b1;
            end else if (tx_valid && link_up_q && (rmii || rgmii)) begin
               st_q <= rpi_pkg::TX_SEND;
               cur_q <= tx_in;
               idx_q <= 2'h0;
               ready_q <= 1'b1;
               txd_q <= sym(tx_in.data, 2'h0, rmii);
               txctl_q <= 1'b1;
            end else begin
               st_q <= rpi_pkg::TX_IDLE;
               idx_q <= 2'h0;
               txd_q <= 4'h0;
               txctl_q <= 1'b0;
            end
         end
         if (rgmii && ref_rise) begin
            if (gig) txd_q <= cur_q.data[7:4];
            txctl_q <= busy ^ (busy & cur_q.err);
         end
      end
   end
   // ==================================================
   // receive assembler
   // error from the fall sample
   assign ferr = dv_q ^ rx_ctl;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sh_q <= 8'h00;
         lo_q <= 4'h0;
         dv_q <= 1'b0;
         racc_q <= 1'b0;
         ridx_q <= 2'h0;
         rrep_q <= 4'h0;
         rvalid_q <= 1'b0;
         rx_q <= '0;
      end else begin
         rvalid_q <= 1'b0;
         if (rgmii) begin
            if (rxc_rise) begin
               dv_q <= rx_ctl;
               lo_q <= rxd;
            end
            if (rxc_fall && dv_q && gig) begin
               rvalid_q <= 1'b1;
               rx_q <= '{ferr, {rxd, lo_q}};
            end else if (rxc_fall && dv_q && ridx_q == 2'h0) begin
               sh_q[3:0] <= lo_q;
               racc_q <= ferr;
               ridx_q <= 2'h1;
            end else if (rxc_fall && dv_q) begin
               rvalid_q <= 1'b1;
               rx_q <= '{ferr | racc_q, {lo_q, sh_q[3:0]}};
               ridx_q <= 2'h0;
            end else if (rxc_fall) begin
               ridx_q <= 2'h0;
            end
         end else if (rmii && ref_rise) begin
            if (!rx_ctl) begin
               ridx_q <= 2'h0;
               rrep_q <= 4'h0;
               racc_q <= 1'b0;
            end else if (rrep_q != 4'h0) begin
               rrep_q <= rrep_q - 4'h1;
            end else begin
               rrep_q <= reload;
               sh_q[{ridx_q, 1'b0} +: 2] <= rxd[1:0];
               racc_q <= (ridx_q != 2'h3) & (racc_q | rxd[3]);
               ridx_q <= ridx_q + 2'h1;
               if (ridx_q == 2'h3) begin
                  rvalid_q <= 1'b1;
                  rx_q <= '{racc_q | rxd[3], {rxd[1:0], sh_q[5:0]}};
               end
            end
         end
      end
   end
   // ==================================================
   // sticky receive error; a new error beats the clear
   always_ff @(posedge clock) begin
      if (sys_rst) rx_err_q <= 1'b0;
      else if (rvalid_q && rx_q.err) rx_err_q <= 1'b1;
      else if (reg_wr && reg_addr == rpi_pkg::ADDR_STAT && reg_wdata[rpi_pkg::STAT_RXERR])
         rx_err_q <= 1'b0;
   end
   // ==================================================
   // read port, data valid only the cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst || !reg_rd) rdata_q <= 32'h0000_0000;
      else begin
         case (reg_addr)
            rpi_pkg::ADDR_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
            rpi_pkg::ADDR_DLY: rdata_q <= {22'h00_0000, dly_q};
            rpi_pkg::ADDR_STAT:
               rdata_q <= {27'h000_0000, cfg_err_q, cfg_q.drive_max, rx_err_q,
                           rgmii ? dv_q : rx_ctl, link_up_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end
   // ==================================================
   // outputs
   assign reg_rdata = rdata_q;
   assign tx_ready = ready_q;
   assign rx_valid = rvalid_q;
   assign rx_out = rx_q;
   assign port_transmit_clock_pin_o = ref_pin;
   assign port_transmit_clock_pin_oe_n = oe_n_q;
   assign port_transmit_control = txctl_q;
   assign port_transmit_data = txd_q;
   assign phy_cfg = cfg_q;
   // ==================================================
   // assertions
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_rmii_spd;
      rmii |=> cfg_q.speed != rpi_pkg::SPD_1000;
   endproperty
   a_rmii_spd: assert property (p_rmii_spd) else $error("rmii at gigabit");
   property p_gig_full;
      (cfg_q.speed == rpi_pkg::SPD_1000) |-> !cfg_q.half_dup;
   endproperty
   a_gig_full: assert property (p_gig_full) else $error("half duplex at 1000");
   property p_link;
      !s2_q[6] |=> link_up_q;
   endproperty
   a_link: assert property (p_link) else $error("link not up on low");
   property p_fall_ctl;
      (rgmii && ref_rise) |=> txctl_q == $past(busy & ~cur_q.err);
   endproperty
   a_fall_ctl: assert property (p_fall_ctl) else $error("bad fall control");
   property p_gig_hi;
      (rgmii && gig && ref_rise) |=> txd_q == $past(cur_q.data[7:4]);
   endproperty
   a_gig_hi: assert property (p_gig_hi) else $error("bad high nibble");
   property p_mac_an;
      ctrl_q.partner_mac |=> !cfg_q.sgmii_an;
   endproperty
   a_mac_an: assert property (p_mac_an) else $error("autoneg with mac partner");
   property p_port;
      !PORT_OK |-> !cfg_q.sgmii_en;
   endproperty
   a_port: assert property (p_port) else $error("sgmii on wrong port");
   property p_hold;
      (slot && rep_q != 4'h0 && rmii) |=> $stable(txd_q);
   endproperty
   a_hold: assert property (p_hold) else $error("symbol not held");
   property p_ready;
      ready_q |-> busy && idx_q == 2'h0;
   endproperty
   a_ready: assert property (p_ready) else $error("take without load");
   c_tx: cover property (ready_q && rgmii && gig);
   c_rx: cover property (rvalid_q && rmii);
   c_err: cover property (rvalid_q && rx_q.err);
endmodule : rpi_port
`default_nettype wire

// ### dv/rpi_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpi_phy_model (
   input wire logic txc,
   input wire logic txctl,
   input wire logic [3:0] txd,
   output logic rxc,
   output logic rxctl,
   output logic [2:0] rxd,
   output logic rxd3
);
   logic [3:0] rq[$];
   logic [4:0] fq[$];
   logic on = 1'b0;
   initial begin
      rxc = 1'b0;
      rxctl = 1'b0;
      rxd = 3'h0;
      rxd3 = 1'b0;
   end
   // ==========
   // transmit monitor
   // looks 1 ns past each edge, the launch skew
   always @(posedge txc) begin
      #1;
      on = txctl;
      if (txctl) rq.push_back(txd);
   end
   always @(negedge txc) begin
      #1;
      if (on) fq.push_back({txctl, txd});
   end
   // ==========
   // receive driver
   // 160 ns clock, dv at rise, dv^er at fall
   task automatic nib(input logic [3:0] d, input logic cf);
      rxd = d[2:0];
      rxd3 = d[3];
      rxctl = 1'b1;
      #40 rxc = 1'b1;
      #40 rxctl = cf;
      #40 rxc = 1'b0;
      #40;
   endtask : nib
   // clock stands still after the closing cycle; lines show stale inverse
   task automatic send_rgmii(input logic [7:0] b, input logic er);
      nib(b[3:0], ~er);
      nib(b[7:4], ~er);
      rxctl = 1'b0;
      rxd = ~rxd;
      rxd3 = ~rxd3;
      #40 rxc = 1'b1;
      #80 rxc = 1'b0;
   endtask : send_rgmii
   // dibits low first, change away from the reference rise
   task automatic send_rmii(input logic [7:0] b, input logic er);
      for (int i = 0; i < 4; i++) begin
         @(negedge txc);
         rxd = {1'b0, b[2*i +: 2]};
         rxctl = 1'b1;
         rxd3 = er;
      end
      @(negedge txc);
      rxctl = 1'b0;
      rxd = ~rxd;
      rxd3 = 1'b0;
   endtask : send_rmii
endmodule : rpi_phy_model
`default_nettype wire

// ### dv/rpi_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module rpi_port_test;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
   logic reg_wr = 1'b0, reg_rd = 1'b0, tx_valid = 1'b0, tx_ready, rx_valid;
   rpi_pkg::rpi_byte_t tx_in = '0, rx_out;
   rpi_pkg::rpi_cfg_t phy_cfg;
   logic txc, oe_n, txctl, rxc, rxctl, rxd3, link_n = 1'b1;
   logic ext_ref = 1'b0;
   logic [3:0] txd;
   logic [2:0] rxd;
   int fails = 0, total_checks = 0, cyc = 0, n;
   realtime t0;
   // 200 MHz clock
   always #2.5 clock = ~clock;
   // external 50 MHz reference, only followed when selected
   always #10 ext_ref = ~ext_ref;
   rpi_port #(.PORT_NUM(1), .IS_HOST(1'b0)) DUT (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
      .tx_in(tx_in), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_out(rx_out),
      .port_transmit_clock_pin_i(ext_ref), .port_transmit_clock_pin_o(txc),
      .port_transmit_clock_pin_oe_n(oe_n), .port_transmit_control(txctl),
      .port_transmit_data(txd), .port_receive_clock(rxc), .port_receive_control(rxctl),
      .port_receive_data(rxd), .port_receive_data_bit3(rxd3),
      .port_link_indication_n(link_n), .strap_drive_hi(1'b0), .strap_rx_delay(1'b0),
      .strap_tx_delay(1'b0), .phy_cfg(phy_cfg)
   );
   rpi_phy_model PHY (.txc(txc), .txctl(txctl), .txd(txd), .rxc(rxc), .rxctl(rxctl),
      .rxd(rxd), .rxd3(rxd3));
   // ==========
   // helpers
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // write, then let the config register settle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // hold the byte until taken, then give the frame time to drain
   task automatic send(input logic [7:0] b, input logic er);
      PHY.rq.delete();
      PHY.fq.delete();
      @(posedge clock);
      tx_in <= {er, b};
      tx_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (tx_ready !== 1'b1 && n < 2000);
      chk("tx taken", 32'(tx_ready), 32'h1);
      tx_valid <= 1'b0;
      repeat (250) @(posedge clock);
   endtask : send
   task automatic wrx();
      n = 0;
      do begin
         @(posedge clock);
         #1 n++;
      end while (rx_valid !== 1'b1 && n < 400);
      chk("rx seen", 32'(rx_valid), 32'h1);
   endtask : wrx
   function automatic logic [31:0] dib(input int s);
      return 32'({PHY.rq[3*s][1:0], PHY.rq[2*s][1:0], PHY.rq[s][1:0], PHY.rq[0][1:0]});
   endfunction : dib
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // cycle ceiling; the run needs well under 10000 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end
   // ==========
   // tests
   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      rd(4'h0);
      chk("ctrl", v, 32'h54);
      rd(4'h1);
      chk("dly", v, 32'h155);
      wr(4'h3, 32'hFF);
      rd(4'h3);
      chk("unmapped", v, 32'h0);
      wr(4'h1, 32'h24F);
      rd(4'h1);
      chk("dly wr", v, 32'h24F);
      chk("taps", 32'({phy_cfg.rx_dly, phy_cfg.tx_dly, phy_cfg.rx_tap, phy_cfg.tx_tap}), 32'h339);
      wr(4'h0, 32'h58);
      chk("clamp", 32'(phy_cfg.speed), 32'h1);
      wr(4'h0, 32'h45);
      chk("half 100", 32'(phy_cfg.half_dup), 32'h1);
      wr(4'h0, 32'h49);
      chk("half 1000", 32'(phy_cfg.half_dup), 32'h0);
      wr(4'h0, 32'h56);
      chk("sgmii an", 32'({phy_cfg.sgmii_en, phy_cfg.sgmii_an}), 32'h3);
      chk("sgmii clk", 32'(oe_n), 32'h1);
      wr(4'h0, 32'hD6);
      chk("mac an", 32'({phy_cfg.sgmii_en, phy_cfg.sgmii_an}), 32'h2);
      wr(4'h0, 32'h54);
      chk("ref out", 32'(oe_n), 32'h0);
      @(posedge txc) t0 = $realtime;
      @(posedge txc) chk("ref period", 32'($rtoi($realtime - t0)), 32'h14);
      rd(4'h2);
      chk("link down", 32'(v[0]), 32'h0);
      @(posedge clock);
      tx_in <= 9'h0A5;
      tx_valid <= 1'b1;
      n = 0;
      repeat (200) begin
         @(posedge clock);
         if (tx_ready === 1'b1) n++;
      end
      tx_valid <= 1'b0;
      link_n <= 1'b0;
      chk("tx refused", n, 32'h0);
      repeat (5) @(posedge clock);
      rd(4'h2);
      chk("link up", 32'(v[0]), 32'h1);
      $display("test config done");
      send(8'hB4, 1'b0);
      chk("rmii100 n", PHY.rq.size(), 32'h4);
      chk("rmii100", dib(1), 32'hB4);
      wr(4'h0, 32'h50);
      send(8'h6D, 1'b0);
      chk("rmii10 n", PHY.rq.size(), 32'h28);
      chk("rmii10", dib(10), 32'h6D);
      wr(4'h0, 32'h55);
      send(8'hA5, 1'b1);
      chk("rgmii100 n", PHY.rq.size(), 32'h2);
      chk("rgmii100", 32'({PHY.rq[1], PHY.rq[0]}), 32'hA5);
      chk("rgmii100 fall", 32'({PHY.fq[1], PHY.fq[0]}), 32'h145);
      wr(4'h0, 32'h59);
      send(8'h6C, 1'b0);
      chk("gig n", PHY.rq.size(), 32'h1);
      chk("gig", 32'({PHY.fq[0], PHY.rq[0]}), 32'h16C);
      $display("test transmit done");
      wr(4'h0, 32'h51);
      fork
         PHY.send_rgmii(8'h93, 1'b0);
         wrx();
      join
      chk("rgmii rx", 32'(rx_out), 32'h93);
      fork
         PHY.send_rgmii(8'h2E, 1'b1);
         wrx();
      join
      chk("rgmii rx err", 32'(rx_out), 32'h12E);
      rd(4'h2);
      chk("err sticky", 32'(v[2]), 32'h1);
      wr(4'h2, 32'h4);
      rd(4'h2);
      chk("err clear", 32'(v[2]), 32'h0);
      wr(4'h0, 32'h54);
      fork
         PHY.send_rmii(8'h5A, 1'b0);
         wrx();
      join
      chk("rmii rx", 32'(rx_out), 32'h5A);
      fork
         PHY.send_rmii(8'hC3, 1'b1);
         wrx();
      join
      chk("rmii rx err", 32'(rx_out), 32'h1C3);
      $display("test receive done");
      wr(4'h0, 32'h74);
      chk("ext oe", 32'(oe_n), 32'h1);
      send(8'h3C, 1'b0);
      chk("ext pin", 32'(txc), 32'h0);
      $display("test external reference done");
      finish_test();
   end
endmodule : rpi_port_test
`default_nettype wire
